// file: logic/mgp_port.sv
// Purpose: Bank of general-purpose pads with per-pad mode, change interrupts and wake.
// Assumes: Pad inputs may change at any time; they are synchronised here.
// Notes: Primary pads come first, additional pads after them in the vectors.
`timescale 1ns/10ps

module mgp_port
#(
  parameter int NUM_PADS = mgp_pkg::MGP_NUM_PRIMARY + mgp_pkg::MGP_NUM_EXTRA
)
(
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Per-pad configuration: two mode bits, one output level bit and one clear bit per pad.
  input wire logic [2*NUM_PADS-1:0] mode_i,
  input wire logic [NUM_PADS-1:0] out_level_i,
  input wire logic [NUM_PADS-1:0] irq_clear_i,
  // Internal function logic side.
  input wire logic [NUM_PADS-1:0] alt_out_i,
  input wire logic [NUM_PADS-1:0] alt_oe_i,
  output logic [NUM_PADS-1:0] alt_in_o,
  // Pad side.
  input wire logic [NUM_PADS-1:0] pad_in_i,
  output logic [NUM_PADS-1:0] pad_out_o,
  output logic [NUM_PADS-1:0] pad_oe_o,
  // Software side.
  output logic [NUM_PADS-1:0] read_level_o,
  output logic [NUM_PADS-1:0] irq_flag_o,
  output logic wake_o
);

  // The wake indices and I2C range must exist in the bank; a smaller bank is refused
  // at elaboration rather than left to index past the vectors.
  if (NUM_PADS < mgp_pkg::MGP_NUM_PRIMARY || NUM_PADS <= mgp_pkg::WAKE_PAD_D)
  begin : g_size_check
    $error("mgp_port needs at least the primary pads");
  end

  // Two-stage synchroniser; stage one feeds stage two only.
  // Reads, flags and wake use sync_b alone, so a metastable first stage never fans out.
  logic [NUM_PADS-1:0] sync_a;
  logic [NUM_PADS-1:0] sync_b;
  logic [NUM_PADS-1:0] last_b;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
      last_b <= '0;
    end
    else if (ce_i)
    begin
      sync_a <= pad_in_i;
      sync_b <= sync_a;
      last_b <= sync_b;
    end
  end

  logic [NUM_PADS-1:0] is_in;
  logic [NUM_PADS-1:0] next_oe;
  logic [NUM_PADS-1:0] next_out;

  // Per-pad decode of mode. Additional pads keep their initial dedicated function
  // while held in the alternative mode; I2C mode is only honoured on primary pads.
  genvar g;
  generate
    for (g = 0; g < NUM_PADS; g++)
    begin : g_pad
      mgp_pkg::mgp_mode_t m;
      assign m = mgp_pkg::mgp_mode_t'(mode_i[2*g +: 2]);
      assign is_in[g] = (m == mgp_pkg::MGP_MODE_IN);
      always_comb
      begin
        next_oe[g] = 1'b0;
        next_out[g] = 1'b0;
        unique case (m)
          mgp_pkg::MGP_MODE_IN:
          begin
            next_oe[g] = 1'b0;
          end
          mgp_pkg::MGP_MODE_OUT:
          begin
            next_oe[g] = 1'b1;
            next_out[g] = out_level_i[g];
          end
          mgp_pkg::MGP_MODE_ALT:
          begin
            next_oe[g] = alt_oe_i[g];
            next_out[g] = alt_out_i[g];
          end
          mgp_pkg::MGP_MODE_I2C:
          begin
            if (g < mgp_pkg::MGP_NUM_I2C)
            begin
              // Open-drain style: drive low only, release for high.
              next_oe[g] = ~alt_out_i[g];
            end
          end
        endcase
      end
    end
  endgenerate

  // Pad drivers, registered so outputs come straight from flops.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_oe_o <= '0;
      pad_out_o <= '0;
    end
    else if (ce_i)
    begin
      pad_oe_o <= next_oe;
      pad_out_o <= next_out;
    end
  end

  // Read path: input pads show the pad, output pads echo the set level.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      read_level_o <= {NUM_PADS{mgp_pkg::MGP_RST_LEVEL}};
      alt_in_o <= '0;
    end
    else if (ce_i)
    begin
      read_level_o <= (sync_b & is_in) | (out_level_i & ~is_in);
      alt_in_o <= sync_b;
    end
  end

  // Change flags on input pads; a new change wins over a clear in the same cycle.
  // The clear is a level, so software should drop it once the flag reads low.
  logic [NUM_PADS-1:0] change;
  assign change = (sync_b ^ last_b) & is_in;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_flag_o <= {NUM_PADS{mgp_pkg::MGP_RST_FLAG}};
    end
    else if (ce_i)
    begin
      irq_flag_o <= change | (irq_flag_o & ~irq_clear_i);
    end
  end

  // Wake only from the four wake-capable pads.
  // Wake is a one-cycle pulse; the sleep controller must latch it.
  logic [NUM_PADS-1:0] wake_mask;
  always_comb
  begin
    wake_mask = '0;
    wake_mask[mgp_pkg::WAKE_PAD_A] = 1'b1;
    wake_mask[mgp_pkg::WAKE_PAD_B] = 1'b1;
    wake_mask[mgp_pkg::WAKE_PAD_C] = 1'b1;
    wake_mask[mgp_pkg::WAKE_PAD_D] = 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wake_o <= |(change & wake_mask);
    end
  end

  // Checks.
  // Pad 0 is at once a primary, a wake and an I2C pad, so most checks watch it.
  irq_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && change[0] |=> irq_flag_o[0])
    else $error("change on input pad did not set its flag");
  out_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode_i[1:0] == 2'b01 |=> pad_oe_o[0] && pad_out_o[0] == $past(out_level_i[0]))
    else $error("output pad not driven with set level");
  in_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode_i[1:0] == 2'b00 |=> !pad_oe_o[0])
    else $error("input pad is driven");
  no_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !(|(change & wake_mask)) |=> !wake_o)
    else $error("wake without wake-pad change");
  sync_lat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##1 ce_i ##1 ce_i |=> alt_in_o == $past(pad_in_i, 3))
    else $error("synchroniser latency wrong");
  alt_path_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode_i[1:0] == 2'b10 |=> pad_oe_o[0] == $past(alt_oe_i[0]))
    else $error("alternative pad not owned by function logic");
  c_irq: cover property (@(posedge clk_i) irq_flag_o[0]);
  c_wake: cover property (@(posedge clk_i) wake_o);
  c_out: cover property (@(posedge clk_i) pad_oe_o[1] && pad_out_o[1]);
  flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && irq_flag_o[0] && !irq_clear_i[0] |=> irq_flag_o[0])
    else $error("change flag dropped without a clear");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && irq_clear_i[0] && !change[0] |=> !irq_flag_o[0])
    else $error("change flag survived its clear");
  out_no_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !is_in[0] && !irq_flag_o[0] |=> !irq_flag_o[0])
    else $error("non-input pad raised a change flag");
  i2c_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mode_i[1:0] == 2'b11 |=> pad_oe_o[0] == !$past(alt_out_i[0]) && !pad_out_o[0])
    else $error("I2C pad not driven open-drain");
  ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(irq_flag_o) && $stable(read_level_o) && $stable(pad_oe_o))
    else $error("state moved while the enable was low");
  // Pads past the I2C range release the pad in I2C mode.
  if (NUM_PADS > mgp_pkg::MGP_NUM_I2C)
  begin : g_i2c_edge
    i2c_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && mode_i[2*mgp_pkg::MGP_NUM_I2C +: 2] == 2'b11 |=> !pad_oe_o[mgp_pkg::MGP_NUM_I2C])
      else $error("pad outside the I2C range driven in I2C mode");
  end
  c_clear: cover property (@(posedge clk_i) irq_flag_o[0] ##1 !irq_flag_o[0]);
  c_freeze: cover property (@(posedge clk_i) !ce_i ##1 ce_i);

endmodule : mgp_port

// file: logic/mgp_pkg.sv
// Purpose: Constants and types shared by the general-purpose pad bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: Pad indices count from zero, so pad 1 of the bank is index 0.
//
// Summary of operation
// - Each pad is set on its own to input, output or alternative function.
// - An input pad is only read, and a read shows the pad level at that time; here a read shows it three clocks late, through the synchroniser.
// - An output pad takes a written level, reads it back, and does not act as an input.
// - An alternative-function pad is driven and sensed by the internal function logic.
// - Any pad set as input can raise an interrupt when its level changes.
// - Only pads 1, 4, 5 and 8 can wake the module from sleep, no other pad can.
// - An output pad drives both high and low as a push-pull stage.
// - Each additional pad starts in its dedicated function and can be switched to plain I/O.
// - The first ten primary pads can also be given to an alternate I2C function.
package mgp_pkg;

  // Pad mode encoding.
  typedef enum logic [1:0]
  {
    MGP_MODE_IN = 2'b00,
    MGP_MODE_OUT = 2'b01,
    MGP_MODE_ALT = 2'b10,
    MGP_MODE_I2C = 2'b11
  } mgp_mode_t;

  // Bank shape: ten primary pads, seventeen additional pads.
  localparam int MGP_NUM_PRIMARY = 10;
  localparam int MGP_NUM_EXTRA = 17;
  localparam int MGP_NUM_I2C = 10;

  // Wake-capable pad indices.
  localparam int WAKE_PAD_A = 0;
  localparam int WAKE_PAD_B = 3;
  localparam int WAKE_PAD_C = 4;
  localparam int WAKE_PAD_D = 7;

  // Reset values.
  localparam logic MGP_RST_LEVEL = 1'b0;
  localparam logic MGP_RST_FLAG = 1'b0;

endpackage : mgp_pkg

// file: dv/mgp_ext_dev.sv
// Purpose: Outside 1.8V devices sharing the pads.
// Assumes: A pad the bank drives wins.
// Notes: Free pads toggle so stale levels show.
`timescale 1ns/10ps
module mgp_ext_dev
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bank and bench side.
  input wire logic [26:0] pad_out_i,
  input wire logic [26:0] pad_oe_i,
  input wire logic [26:0] ext_level_i,
  input wire logic [26:0] ext_oe_i,
  output logic [26:0] pad_o
);
  logic [26:0] idle;
  // Free pads alternate, but stay low in reset to avoid a boot strap.
  always_ff @(posedge clk_i)
    idle <= rst_i ? '0 : ~idle;
  // Bank drive first, then the outside driver at CMOS levels.
  always_comb
    pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ((ext_oe_i & ext_level_i)
      | (~ext_oe_i & idle)));
endmodule : mgp_ext_dev

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the pad bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: One scenario drops the enable, and the same one resets the bank in mid-run.
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 0, rst_i = 1, ce_i = 1, wake_o, woke = 0;
  logic [53:0] mode_i = '0;
  logic [26:0] out_level_i = '0, irq_clear_i = '0, alt_out_i = '0, alt_oe_i = '0;
  logic [26:0] ext_level = '0, ext_oe = '1, pad_in_i, alt_in_o, pad_out_o, pad_oe_o;
  logic [26:0] read_level_o, irq_flag_o;
  int fails = 0, compares = 0;
  // Half period of 2.5 ns.
  always #2.5 clk_i = ~clk_i;
  mgp_port uut (.clk_i, .rst_i, .ce_i, .mode_i, .out_level_i, .irq_clear_i, .alt_out_i,
    .alt_oe_i, .alt_in_o, .pad_in_i, .pad_out_o, .pad_oe_o, .read_level_o, .irq_flag_o,
    .wake_o);
  mgp_ext_dev ext (.clk_i, .rst_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .ext_level_i(ext_level), .ext_oe_i(ext_oe), .pad_o(pad_in_i));
  task automatic check(input string what, input logic [26:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Steps edges and catches any one-cycle wake pulse.
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1;
      woke |= wake_o;
    end
  endtask : step
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // A rising input pad, its flag, its wake and the clear.
  task automatic in_change(input int k, input logic wakes);
    woke = 0;
    ext_level[k] = 1;
    step(2);
    check("early", read_level_o[k], 0);
    step(2);
    check("read", read_level_o[k], 1);
    check("flag", irq_flag_o, 27'h1 << k);
    check("wake", woke, wakes);
    irq_clear_i[k] = 1;
    step(1);
    irq_clear_i[k] = 0;
    step(1);
    check("clear", irq_flag_o, 0);
  endtask : in_change
  // Output pads drive both levels, read back, and raise no flag.
  task automatic out_mode();
    mode_i = 54'h15_5555_5555_5555;
    ext_oe = '0;
    out_level_i = 27'h555_5555;
    step(5);
    irq_clear_i = '1;
    step(1);
    irq_clear_i = '0;
    out_level_i = ~out_level_i;
    step(1);
    check("oe", pad_oe_o, '1);
    check("drive", pad_out_o, 27'h2aa_aaaa);
    check("back", read_level_o, 27'h2aa_aaaa);
    step(4);
    check("noflag", irq_flag_o, 0);
  endtask : out_mode
  // Function logic owns the pads; then I2C only on the first ten.
  task automatic alt_mode();
    mode_i = 54'h2a_aaaa_aaaa_aaaa;
    alt_oe_i = 27'h0f0_f0f0;
    alt_out_i = 27'h555_5555;
    ext_oe = ~alt_oe_i;
    ext_level = 27'h333_3333;
    step(4);
    check("aoe", pad_oe_o, alt_oe_i);
    check("aout", pad_out_o & alt_oe_i, alt_out_i & alt_oe_i);
    check("ain", alt_in_o, (alt_oe_i & alt_out_i) | (ext_oe & ext_level));
    mode_i = '1;
    step(1);
    check("i2c", pad_oe_o, ~alt_out_i & 27'h3ff);
    check("i2cout", pad_out_o, 0);
  endtask : alt_mode
  // Enable low freezes the bank; a falling pad flags even under a held clear; mid-run reset.
  task automatic freeze();
    mode_i = '0;
    ext_oe = '1;
    ext_level = '0;
    irq_clear_i = '1;
    step(6);
    irq_clear_i = '0;
    ce_i = 0;
    ext_level[1] = 1;
    step(6);
    check("frozen", read_level_o[1], 0);
    check("fzflag", irq_flag_o, 0);
    ce_i = 1;
    woke = 0;
    step(4);
    check("thawed", read_level_o[1], 1);
    check("flag1", irq_flag_o, 27'h2);
    check("nowake", woke, 0);
    irq_clear_i[1] = 1;
    ext_level[1] = 0;
    step(3);
    check("setwins", irq_flag_o, 27'h2);
    step(1);
    check("cleared", irq_flag_o, 0);
    irq_clear_i[1] = 0;
    rst_i = 1;
    step(2);
    check("rstflag", irq_flag_o, 0);
    check("rstoe", pad_oe_o, 0);
    rst_i = 0;
    ext_level = '1;
    step(3);
    check("reflag", irq_flag_o, '1);
  endtask : freeze
  initial
  begin
    step(8);
    rst_i = 0;
    for (int k = 0; k < 27; k++)
      in_change(k, k inside {0, 3, 4, 7});
    out_mode();
    alt_mode();
    freeze();
    final_report();
  end
  // About 211 cycles are needed.
  initial
  begin
    #20000;
    fails++;
    final_report();
  end
endmodule : tb_top
